/* power_mode_consts.vh */
// Constants for the memory power mode controller
// Assumes a 10 MHz core clock
`ifndef POWER_MODE_CONSTS_VH
`define POWER_MODE_CONSTS_VH
// ----------------------------------------
// Timing in native units
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define INITIAL_ACCESS_TIME_NS 35
`define CLOCK_STOP_MARGIN_NS 30
`define SLEEP_ENTRY_TIME_US 3
`define SLEEP_EXIT_MIN_NS 60
`define SLEEP_EXIT_MAX_NS 3000
`define SLEEP_WAKEUP_TIME_US 100
`define POWERDOWN_ENTRY_TIME_US 3
`define POWERDOWN_EXIT_MIN_NS 200
`define POWERDOWN_EXIT_MAX_NS 3000
`define POWERDOWN_WAKEUP_TIME_US 150
// ----------------------------------------
// Cycle counts
// ----------------------------------------
`define CLOCK_STOP_CYC ((`INITIAL_ACCESS_TIME_NS + `CLOCK_STOP_MARGIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLEEP_ENTRY_CYC ((`SLEEP_ENTRY_TIME_US * 1000) / `CLK_PERIOD_NS)
`define SLEEP_EXIT_MIN_CYC ((`SLEEP_EXIT_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLEEP_EXIT_MAX_CYC (`SLEEP_EXIT_MAX_NS / `CLK_PERIOD_NS)
`define SLEEP_WAKEUP_CYC ((`SLEEP_WAKEUP_TIME_US * 1000) / `CLK_PERIOD_NS)
`define POWERDOWN_ENTRY_CYC ((`POWERDOWN_ENTRY_TIME_US * 1000) / `CLK_PERIOD_NS)
`define POWERDOWN_EXIT_MIN_CYC ((`POWERDOWN_EXIT_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWERDOWN_EXIT_MAX_CYC (`POWERDOWN_EXIT_MAX_NS / `CLK_PERIOD_NS)
`define POWERDOWN_WAKEUP_CYC ((`POWERDOWN_WAKEUP_TIME_US * 1000) / `CLK_PERIOD_NS)
// ----------------------------------------
// Register fields and resets
// ----------------------------------------
`define SLEEP_REQ_BIT 5
`define POWER_ON_BIT 15
`define CFG_ZERO_RESET 16'h8f1f
`define CFG_ONE_RESET 16'h0001
`define TIMER_W 12
`endif

/* read_data_latch.v */
// Read data latch held during active clock stop
// Assumes load comes from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module read_data_latch #(
   parameter WIDTH = 8
) (
   input wire i_clk,
   input wire i_resetn,
   input wire i_ce,
   input wire i_load,
   input wire [WIDTH-1:0] i_data,
   output reg [WIDTH-1:0] o_data
);
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         o_data <= {WIDTH{1'b0}};
      end else if (i_ce && i_load) begin
         o_data <= i_data;
      end
   end
endmodule // read_data_latch
`default_nettype wire

/* memory_power_mode_control.v */
// Power mode state control of a self-refreshing DDR memory
// Assumes chip select and bus clock are asynchronous pins
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_consts.vh"
module memory_power_mode_control #(
   parameter DATA_W = 8,
   parameter SLEEP_WAKEUP_CYCLES = `SLEEP_WAKEUP_CYC,
   parameter POWERDOWN_WAKEUP_CYCLES = `POWERDOWN_WAKEUP_CYC
) (
   input wire i_clk,
   input wire i_resetn,
   input wire i_ce,
   input wire i_select_n,
   input wire i_bus_clk,
   input wire i_read_phase,
   input wire i_data_phase,
   input wire i_command_address_phase,
   input wire [DATA_W-1:0] i_read_data,
   input wire i_cfg_write,
   input wire i_cfg_sel_one,
   input wire [15:0] i_cfg_wdata,
   output reg [DATA_W-1:0] o_dq,
   output reg o_dq_oe,
   output reg o_read_write_data_strobe,
   output reg o_read_write_data_strobe_oe,
   output reg o_standby,
   output reg o_clock_stop,
   output reg o_hybrid_sleep,
   output reg o_deep_power_down,
   output reg o_waking,
   output reg o_refresh_on,
   output reg o_array_valid,
   output reg [15:0] o_configuration_register_zero,
   output reg [15:0] o_configuration_register_one
);
   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam [2:0] ST_RUN = 3'h0;
   localparam [2:0] ST_SLEEP_IN = 3'h1;
   localparam [2:0] ST_SLEEP = 3'h2;
   localparam [2:0] ST_SLEEP_WAKE = 3'h3;
   localparam [2:0] ST_PD_IN = 3'h4;
   localparam [2:0] ST_PD = 3'h5;
   localparam [2:0] ST_PD_WAKE = 3'h6;
   localparam integer STOP_I = `CLOCK_STOP_CYC, SIN_I = `SLEEP_ENTRY_CYC, PIN_I = `POWERDOWN_ENTRY_CYC;
   localparam integer SMIN_I = `SLEEP_EXIT_MIN_CYC, SMAX_I = `SLEEP_EXIT_MAX_CYC;
   localparam integer PMIN_I = `POWERDOWN_EXIT_MIN_CYC, PMAX_I = `POWERDOWN_EXIT_MAX_CYC;
   localparam [`TIMER_W-1:0] STOP_CYC = STOP_I[`TIMER_W-1:0];
   localparam [`TIMER_W-1:0] S_IN_CYC = SIN_I[`TIMER_W-1:0];
   localparam [`TIMER_W-1:0] P_IN_CYC = PIN_I[`TIMER_W-1:0];
   localparam [`TIMER_W-1:0] S_MIN = SMIN_I[`TIMER_W-1:0];
   localparam [`TIMER_W-1:0] S_MAX = SMAX_I[`TIMER_W-1:0];
   localparam [`TIMER_W-1:0] P_MIN = PMIN_I[`TIMER_W-1:0];
   localparam [`TIMER_W-1:0] P_MAX = PMAX_I[`TIMER_W-1:0];
   localparam [`TIMER_W-1:0] TIMER_ONE = 12'h001;
   localparam [31:0] S_WAKE = SLEEP_WAKEUP_CYCLES;
   localparam [31:0] P_WAKE = POWERDOWN_WAKEUP_CYCLES;
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   reg sel_meta;
   reg sel_sync;
   reg sel_prev;
   reg ck_meta;
   reg ck_sync;
   reg ck_prev;
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         sel_meta <= 1'b1;
         sel_sync <= 1'b1;
         sel_prev <= 1'b1;
         ck_meta <= 1'b0;
         ck_sync <= 1'b0;
         ck_prev <= 1'b0;
      end else if (i_ce) begin
         sel_meta <= i_select_n;
         sel_sync <= sel_meta;
         sel_prev <= sel_sync;
         ck_meta <= i_bus_clk;
         ck_sync <= ck_meta;
         ck_prev <= ck_sync;
      end
   end
   wire selected = !sel_sync;
   wire sel_rise = sel_sync && !sel_prev;
   wire ck_edge = ck_sync ^ ck_prev;
   // ----------------------------------------
   // Pulse width check
   // ----------------------------------------
   function in_window;
      input [`TIMER_W-1:0] width;
      input [`TIMER_W-1:0] lo;
      input [`TIMER_W-1:0] hi;
      begin
         in_window = (width >= lo) && (width <= hi);
      end
   endfunction
   // ----------------------------------------
   // Active clock stop
   // ----------------------------------------
   reg [`TIMER_W-1:0] idle_cnt;
   reg [2:0] state;
   reg [2:0] next_state;
   wire running = (state == ST_RUN) || (state == ST_SLEEP_IN) || (state == ST_PD_IN);
   wire in_transfer = running && selected && i_data_phase;
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         idle_cnt <= {`TIMER_W{1'b0}};
         o_clock_stop <= 1'b0;
      end else if (i_ce) begin
         if (!in_transfer || ck_edge) begin
            idle_cnt <= {`TIMER_W{1'b0}};
            o_clock_stop <= 1'b0;
         end else if (idle_cnt >= STOP_CYC - TIMER_ONE) begin
            o_clock_stop <= 1'b1;
         end else begin
            idle_cnt <= idle_cnt + TIMER_ONE;
         end
      end
   end
   // ----------------------------------------
   // Read data path
   // ----------------------------------------
   wire [DATA_W-1:0] held_data;
   wire rd_drive = running && selected && i_read_phase && i_data_phase;
   read_data_latch #(
      .WIDTH(DATA_W)
   ) u_latch (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_ce(i_ce),
      .i_load(rd_drive && !o_clock_stop),
      .i_data(i_read_data),
      .o_data(held_data)
   );
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         o_dq <= {DATA_W{1'b0}};
         o_dq_oe <= 1'b0;
         o_read_write_data_strobe <= 1'b0;
         o_read_write_data_strobe_oe <= 1'b0;
      end else if (i_ce) begin
         o_dq <= o_clock_stop ? held_data : i_read_data;
         o_dq_oe <= rd_drive;
         o_read_write_data_strobe <= rd_drive && !o_clock_stop && ck_sync;
         if (running && selected && i_command_address_phase) begin
            o_read_write_data_strobe_oe <= 1'b1;
         end else begin
            o_read_write_data_strobe_oe <= rd_drive;
         end
      end
   end
   // ----------------------------------------
   // Power mode sequencer
   // ----------------------------------------
   reg [`TIMER_W-1:0] low_cnt;
   reg [31:0] timer;
   reg [15:0] saved_one;
   wire cfg_wr = i_cfg_write && running && selected;
   wire sleep_req = cfg_wr && i_cfg_sel_one && i_cfg_wdata[`SLEEP_REQ_BIT];
   wire pd_req = cfg_wr && !i_cfg_sel_one && !i_cfg_wdata[`POWER_ON_BIT];
   always @* begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (pd_req) begin
               next_state = ST_PD_IN;
            end else if (sleep_req) begin
               next_state = ST_SLEEP_IN;
            end
         end
         ST_SLEEP_IN: begin
            if (timer + 32'h00000001 >= {20'h00000, S_IN_CYC}) begin
               next_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (sel_rise && in_window(low_cnt, S_MIN, S_MAX)) begin
               next_state = ST_SLEEP_WAKE;
            end
         end
         ST_SLEEP_WAKE: begin
            if (timer >= S_WAKE) begin
               next_state = ST_RUN;
            end
         end
         ST_PD_IN: begin
            if (timer + 32'h00000001 >= {20'h00000, P_IN_CYC}) begin
               next_state = ST_PD;
            end
         end
         ST_PD: begin
            if (sel_rise && in_window(low_cnt, P_MIN, P_MAX)) begin
               next_state = ST_PD_WAKE;
            end
         end
         ST_PD_WAKE: begin
            if (timer >= P_WAKE) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         state <= ST_RUN;
         timer <= 32'h00000000;
         low_cnt <= {`TIMER_W{1'b0}};
         saved_one <= `CFG_ONE_RESET;
         o_configuration_register_zero <= `CFG_ZERO_RESET;
         o_configuration_register_one <= `CFG_ONE_RESET;
         o_refresh_on <= 1'b0;
         o_array_valid <= 1'b0;
      end else if (i_ce) begin
         state <= next_state;
         timer <= (next_state != state) ? 32'h00000000 : timer + 32'h00000001;
         if (sel_sync) begin
            low_cnt <= {`TIMER_W{1'b0}};
         end else if (low_cnt != {`TIMER_W{1'b1}}) begin
            low_cnt <= low_cnt + TIMER_ONE;
         end
         if (state == ST_RUN) begin
            o_refresh_on <= 1'b1;
            if (cfg_wr && i_cfg_sel_one) begin
               o_configuration_register_one <= i_cfg_wdata;
               saved_one <= i_cfg_wdata;
            end else if (cfg_wr) begin
               o_configuration_register_zero <= i_cfg_wdata;
            end
            if (cfg_wr || selected) begin
               o_array_valid <= 1'b1;
            end
         end
         if (next_state == ST_PD_IN) begin
            o_refresh_on <= 1'b0;
            o_array_valid <= 1'b0;
         end
         if (state == ST_PD && next_state == ST_PD_WAKE) begin
            o_configuration_register_zero <= `CFG_ZERO_RESET;
            o_configuration_register_one <= `CFG_ONE_RESET;
         end
         if (state == ST_SLEEP && next_state == ST_SLEEP_WAKE) begin
            // Sleep keeps contents; only the request bit drops
            o_configuration_register_one <= saved_one & ~(16'h0001 << `SLEEP_REQ_BIT);
         end
      end
   end
   // ----------------------------------------
   // Status outputs
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         o_standby <= 1'b1;
         o_hybrid_sleep <= 1'b0;
         o_deep_power_down <= 1'b0;
         o_waking <= 1'b0;
      end else if (i_ce) begin
         o_standby <= (next_state == ST_RUN) && sel_sync;
         o_hybrid_sleep <= next_state == ST_SLEEP;
         o_deep_power_down <= next_state == ST_PD;
         o_waking <= (next_state == ST_SLEEP_WAKE) || (next_state == ST_PD_WAKE);
      end
   end
endmodule // memory_power_mode_control
`default_nettype wire

/* mpm_chk.sv */
// Checker of the memory power mode controller
// Sees only top ports; attached by the bind below
`timescale 1ns/1ps
`default_nettype none
module mpm_chk #(
   parameter int POWERDOWN_WAKEUP_CYCLES = 1500
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_select_n,
   input wire logic i_bus_clk,
   input wire logic i_read_phase,
   input wire logic i_data_phase,
   input wire logic i_command_address_phase,
   input wire logic i_cfg_write,
   input wire logic [7:0] o_dq,
   input wire logic o_dq_oe,
   input wire logic o_read_write_data_strobe,
   input wire logic o_clock_stop,
   input wire logic o_hybrid_sleep,
   input wire logic o_deep_power_down,
   input wire logic o_waking,
   input wire logic o_refresh_on,
   input wire logic o_array_valid,
   input wire logic [15:0] o_configuration_register_zero,
   input wire logic [15:0] o_configuration_register_one
);
   // ----------------------------------------
   // Helper counters
   // ----------------------------------------
   logic [5:0] since_write;
   logic [11:0] wake_cnt;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         since_write <= 6'h3f;
         wake_cnt <= 12'h000;
      end else begin
         since_write <= i_cfg_write ? 6'h00 : (since_write == 6'h3f ? since_write : since_write + 6'h01);
         wake_cnt <= o_waking ? wake_cnt + 12'h001 : 12'h000;
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   sequence s_sleep_exit;
      $fell(o_hybrid_sleep) ##0 o_waking;
   endsequence
   sequence s_deselected;
      i_select_n [*4];
   endsequence
   a_sleep_entry_time: assert property ($rose(o_hybrid_sleep) |-> since_write <= 6'h1e)
      else $error("sleep entry late");
   a_pd_entry_time: assert property ($rose(o_deep_power_down) |-> since_write <= 6'h1e)
      else $error("powerdown entry late");
   a_pd_no_refresh: assert property (o_deep_power_down |-> !o_refresh_on && !o_array_valid)
      else $error("refresh in powerdown");
   a_sleep_exit_clear: assert property (s_sleep_exit |-> !o_configuration_register_one[5])
      else $error("sleep bit not cleared");
   a_pd_exit_default: assert property ($fell(o_deep_power_down) |-> ##[0:1] o_configuration_register_zero == 16'h8f1f)
      else $error("powerdown exit not default");
   a_wake_bounded: assert property (wake_cnt <= POWERDOWN_WAKEUP_CYCLES + 1)
      else $error("wakeup too long");
   a_deselect_quiet: assert property (s_deselected |-> !o_dq_oe && !o_clock_stop)
      else $error("active while deselected");
   a_stop_latched: assert property (o_clock_stop && $past(o_clock_stop) && i_read_phase |-> o_dq_oe && $stable(o_dq))
      else $error("stop data not held");
   a_stop_resumes: assert property (o_clock_stop && $changed(i_bus_clk) |-> ##[1:5] !o_clock_stop)
      else $error("stop not left");
   a_stop_in_data: assert property ($rose(o_clock_stop) |-> $past(i_data_phase))
      else $error("stop outside data");
   a_strobe_cmd_low: assert property (i_command_address_phase && !i_select_n |-> !o_read_write_data_strobe)
      else $error("strobe high in command");
endmodule // mpm_chk
bind memory_power_mode_control mpm_chk #(.POWERDOWN_WAKEUP_CYCLES(POWERDOWN_WAKEUP_CYCLES)) mpm_chk_inst (.*);
`default_nettype wire

/* host_model.sv */
// Host controller model driving select and bus clock
// Assumes the bench commands select and clock running
`timescale 1ns/1ps
`default_nettype none
module host_model #(
   parameter int MAX_LOW_CYC = 40
) (
   input wire logic i_clk,
   input wire logic i_select,
   input wire logic i_run_clk,
   output logic o_select_n,
   output logic o_bus_clk
);
   int low_cnt = 0;
   initial o_select_n = 1'b1;
   always @(posedge i_clk) begin
      low_cnt <= o_select_n ? 0 : low_cnt + 1;
      o_select_n <= !(i_select && low_cnt < MAX_LOW_CYC);
   end
   // Bus clock parks low when paused
   initial begin
      o_bus_clk = 1'b0;
      #137;
      forever begin
         #400;
         if (i_run_clk || o_bus_clk) o_bus_clk = ~o_bus_clk;
      end
   end
endmodule // host_model
`default_nettype wire

/* tb_top.sv */
// Bench of the memory power mode controller
// Assumes host_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic sel = 1'b0, run = 1'b0, rd = 1'b0, dph = 1'b0, cap = 1'b0, wr = 1'b0, one = 1'b0;
   logic [7:0] rdata = 8'h00;
   logic [15:0] wdata = 16'h0000;
   wire select_n, bus_clk, dq_oe, strobe, strobe_oe, standby, stop, sleep, pd, waking, refresh, valid;
   wire [7:0] dq;
   wire [15:0] cfg0, cfg1;
   int mismatches = 0, num_checks = 0, cyc = 0, k;
   host_model host_model_inst (.i_clk(i_clk), .i_select(sel), .i_run_clk(run), .o_select_n(select_n),
      .o_bus_clk(bus_clk));
   memory_power_mode_control #(.SLEEP_WAKEUP_CYCLES(20), .POWERDOWN_WAKEUP_CYCLES(20)) memory_power_mode_control_inst (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(1'b1), .i_select_n(select_n), .i_bus_clk(bus_clk),
      .i_read_phase(rd), .i_data_phase(dph), .i_command_address_phase(cap), .i_read_data(rdata),
      .i_cfg_write(wr), .i_cfg_sel_one(one), .i_cfg_wdata(wdata), .o_dq(dq), .o_dq_oe(dq_oe),
      .o_read_write_data_strobe(strobe), .o_read_write_data_strobe_oe(strobe_oe), .o_standby(standby),
      .o_clock_stop(stop), .o_hybrid_sleep(sleep), .o_deep_power_down(pd), .o_waking(waking),
      .o_refresh_on(refresh), .o_array_valid(valid), .o_configuration_register_zero(cfg0),
      .o_configuration_register_one(cfg1));
   initial forever #50 i_clk = ~i_clk;
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk_word(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task chk_bit(input logic got, input logic exp);
      chk_word({15'h0000, got}, {15'h0000, exp});
   endtask
   task step(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task do_reset(input int n);
      i_resetn <= 1'b0;
      step(n);
      i_resetn <= 1'b1;
      step(4);
   endtask
   task cfg_wr(input logic s, input logic [15:0] d);
      sel <= 1'b1;
      run <= 1'b1;
      step(6);
      wr <= 1'b1;
      one <= s;
      wdata <= d;
      step(1);
      wr <= 1'b0;
      sel <= 1'b0;
      run <= 1'b0;
      k = 0;
      while (sleep !== 1'b1 && pd !== 1'b1 && k < 40) begin
         step(1);
         k++;
      end
   endtask
   task pulse(input int n);
      sel <= 1'b1;
      step(n);
      sel <= 1'b0;
      step(6);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_sleep;
      cfg_wr(1'b1, 16'h0021);
      chk_bit(k <= 31, 1'b1);
      chk_word(cfg0, 16'h8f1f);
      chk_word(cfg1, 16'h0021);
      pulse(35);
      chk_bit(sleep, 1'b1);
      pulse(5);
      chk_bit(waking, 1'b1);
      chk_word(cfg1, 16'h0001);
      step(24);
      chk_bit(standby, 1'b1);
   endtask
   task t_powerdown;
      cfg_wr(1'b0, 16'h0f1f);
      chk_bit(k <= 31, 1'b1);
      chk_bit(refresh, 1'b0);
      chk_bit(valid, 1'b0);
      pulse(1);
      chk_bit(pd, 1'b1);
      pulse(5);
      chk_bit(waking, 1'b1);
      step(24);
      chk_bit(standby, 1'b1);
      chk_word(cfg0, 16'h8f1f);
   endtask
   task t_reset_exit;
      cfg_wr(1'b1, 16'h0021);
      do_reset(3);
      chk_bit(sleep, 1'b0);
      cfg_wr(1'b0, 16'h0f1f);
      do_reset(3);
      chk_bit(pd, 1'b0);
      chk_word(cfg0, 16'h8f1f);
   endtask
   task t_clock_stop;
      sel <= 1'b1;
      rd <= 1'b1;
      dph <= 1'b1;
      rdata <= 8'ha5;
      run <= 1'b1;
      step(12);
      run <= 1'b0;
      step(8);
      k = 0;
      while (stop !== 1'b1 && k < 12) begin
         step(1);
         k++;
      end
      chk_bit(stop, 1'b1);
      rdata <= 8'h3c;
      step(2);
      chk_word({8'h00, dq}, 16'h00a5);
      chk_bit(dq_oe, 1'b1);
      run <= 1'b1;
      k = 0;
      while (stop !== 1'b0 && k < 12) begin
         step(1);
         k++;
      end
      chk_bit(stop, 1'b0);
      step(1);
      chk_word({8'h00, dq}, 16'h003c);
      run <= 1'b0;
      rd <= 1'b0;
      dph <= 1'b0;
      sel <= 1'b0;
      step(4);
   endtask
   task t_command;
      wr <= 1'b1;
      one <= 1'b1;
      wdata <= 16'h0021;
      step(1);
      wr <= 1'b0;
      step(4);
      chk_word(cfg1, 16'h0001);
      sel <= 1'b1;
      rd <= 1'b1;
      cap <= 1'b1;
      step(6);
      chk_bit(strobe, 1'b0);
      chk_bit(strobe_oe, 1'b1);
      cap <= 1'b0;
      rd <= 1'b0;
      sel <= 1'b0;
      step(4);
   endtask
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         stop_test;
      end
   end
   initial begin
      do_reset(5);
      chk_word(cfg0, 16'h8f1f);
      chk_word(cfg1, 16'h0001);
      chk_bit(standby, 1'b1);
      t_command;
      t_sleep;
      t_powerdown;
      t_reset_exit;
      t_clock_stop;
      stop_test;
   end
endmodule // tb_top
`default_nettype wire
